// ==== src/peripheral_irq_enable_gating.sv ====
// Top of the peripheral interrupt enable block with flag gating and the bus slave.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_enable_gating (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [pirq_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [pirq_pkg::DATA_W-1:0] avs_writedata_i,
    output logic [pirq_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [pirq_pkg::REG_W-1:0] event_i,
    input wire logic serial_rx_full_i,
    input wire logic serial_tx_empty_i,
    output logic [pirq_pkg::REG_W-1:0] peripheral_irq_enable_o,
    output logic [pirq_pkg::REG_W-1:0] peripheral_irq_flags_o,
    output logic irq_o
);
    import pirq_pkg::*;

    reg_link_if link ();

    logic [REG_W-1:0] peripheral_irq_enable_r;
    logic [REG_W-1:0] peripheral_irq_enable_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [REG_W-1:0] flags_shadow_r;

    pirq_avalon_slave u_slave (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .link(link.slave)
    );

    pirq_flag_bank u_flags (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .event_i(event_i),
        .serial_rx_full_i(serial_rx_full_i),
        .serial_tx_empty_i(serial_tx_empty_i),
        .link(link.bank)
    );

    // Read mux: unmapped addresses read as zero, bit 3 always zero.
    always_comb begin
        if (reg_hit(link.addr, PERIPHERAL_IRQ_ENABLE_OFFSET)) begin
            link.rd_value = to_word(peripheral_irq_enable_r & IMPL_MASK);
        end else if (reg_hit(link.addr, PERIPHERAL_IRQ_FLAGS_OFFSET)) begin
            link.rd_value = to_word(link.flags & IMPL_MASK);
        end else begin
            link.rd_value = READ_ZERO;
        end
    end

    // Writing a one to a latched flag clears it; apart from reset, nothing else clears it.
    always_comb begin
        if (link.wr_commit && reg_hit(link.addr, PERIPHERAL_IRQ_FLAGS_OFFSET)) begin
            link.flag_clr = link.wdata & LATCHED_MASK;
        end else begin
            link.flag_clr = '0;
        end
    end

    // Enable register write and the gated interrupt level.
    always_comb begin
        peripheral_irq_enable_nxt = peripheral_irq_enable_r;
        if (link.wr_commit && reg_hit(link.addr, PERIPHERAL_IRQ_ENABLE_OFFSET)) begin
            peripheral_irq_enable_nxt = link.wdata & IMPL_MASK;
        end
        irq_nxt = |(link.flags & peripheral_irq_enable_r & IMPL_MASK);
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            peripheral_irq_enable_r <= ENABLE_RESET;
            irq_r <= 1'b0;
            flags_shadow_r <= FLAGS_RESET;
        end else if (ce_i) begin
            peripheral_irq_enable_r <= peripheral_irq_enable_nxt;
            irq_r <= irq_nxt;
            flags_shadow_r <= link.flags;
        end
    end

    assign peripheral_irq_enable_o = peripheral_irq_enable_r;
    assign peripheral_irq_flags_o = flags_shadow_r;
    assign irq_o = irq_r;
endmodule
`default_nettype wire

// ==== src/pirq_pkg.sv ====
// Constants, register map and helper functions of the peripheral interrupt enable block.
package pirq_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;

    localparam logic [ADDR_W-1:0] PERIPHERAL_IRQ_ENABLE_OFFSET = 8'h8C;
    localparam logic [ADDR_W-1:0] PERIPHERAL_IRQ_FLAGS_OFFSET = 8'h0C;

    localparam int unsigned NV_WRITE_DONE_BIT = 7;
    localparam int unsigned COMPARATOR_BIT = 6;
    localparam int unsigned SERIAL_RX_BIT = 5;
    localparam int unsigned SERIAL_TX_BIT = 4;
    localparam int unsigned UNUSED_BIT = 3;
    localparam int unsigned CAPTURE_COMPARE_BIT = 2;
    localparam int unsigned TIMER_B_MATCH_BIT = 1;
    localparam int unsigned TIMER_A_OVERFLOW_BIT = 0;

    localparam logic [REG_W-1:0] ENABLE_RESET = 8'h00;
    localparam logic [REG_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [REG_W-1:0] IMPL_MASK = 8'hF7;
    localparam logic [REG_W-1:0] LATCHED_MASK = 8'hC7;
    localparam logic [REG_W-1:0] LEVEL_MASK = 8'h30;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } bus_state_type;

    // True when a byte address selects the given register.
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
        reg_hit = (addr == offset);
    endfunction

    // Widens an 8-bit register image into the low bits of a bus word.
    function automatic logic [DATA_W-1:0] to_word(input logic [REG_W-1:0] value);
        to_word = {{(DATA_W-REG_W){1'b0}}, value};
    endfunction
endpackage

// ==== src/reg_link_if.sv ====
// Carrier between the bus slave, the flag bank and the top of the interrupt enable block.
`timescale 1ns/1ps
`default_nettype none
interface reg_link_if;
    logic wr_commit;
    logic [pirq_pkg::ADDR_W-1:0] addr;
    logic [pirq_pkg::REG_W-1:0] wdata;
    logic [pirq_pkg::DATA_W-1:0] rd_value;
    logic [pirq_pkg::REG_W-1:0] flag_clr;
    logic [pirq_pkg::REG_W-1:0] flags;

    modport slave (output wr_commit, output addr, output wdata, input rd_value);
    modport core (input wr_commit, input addr, input wdata, output rd_value, output flag_clr, input flags);
    modport bank (input flag_clr, output flags);
endinterface
`default_nettype wire

// ==== src/pirq_avalon_slave.sv ====
// Avalon-MM slave with one wait cycle that hands register accesses to the block.
`timescale 1ns/1ps
`default_nettype none
module pirq_avalon_slave (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [pirq_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [pirq_pkg::DATA_W-1:0] avs_writedata_i,
    output logic [pirq_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    reg_link_if.slave link
);
    import pirq_pkg::*;

    bus_state_type state_r;
    bus_state_type state_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic wait_r;
    logic wait_nxt;

    assign link.addr = avs_address_i;
    assign link.wdata = avs_writedata_i[REG_W-1:0];
    assign link.wr_commit = ce_i && avs_write_i && (state_r == BUS_ACK);
    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;

    always_comb begin
        state_nxt = state_r;
        rdata_nxt = rdata_r;
        case (state_r)
            BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    state_nxt = BUS_ACK;
                    rdata_nxt = avs_read_i ? link.rd_value : READ_ZERO;
                end
            end
            BUS_ACK: begin
                state_nxt = BUS_IDLE;
            end
            default: begin
                state_nxt = BUS_IDLE;
            end
        endcase
        // Waitrequest comes from its own flop so the port is glitch free.
        wait_nxt = (state_nxt != BUS_ACK);
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= BUS_IDLE;
            rdata_r <= READ_ZERO;
            wait_r <= 1'b1;
        end else if (ce_i) begin
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== src/pirq_flag_bank.sv ====
// Companion flag register: latched event flags and live buffer-state flags.
`timescale 1ns/1ps
`default_nettype none
module pirq_flag_bank (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [pirq_pkg::REG_W-1:0] event_i,
    input wire logic serial_rx_full_i,
    input wire logic serial_tx_empty_i,
    reg_link_if.bank link
);
    import pirq_pkg::*;

    logic [REG_W-1:0] flags_r;
    logic [REG_W-1:0] flags_nxt;
    logic [REG_W-1:0] level_now;

    assign link.flags = flags_r;

    always_comb begin
        level_now = '0;
        level_now[SERIAL_RX_BIT] = serial_rx_full_i;
        level_now[SERIAL_TX_BIT] = serial_tx_empty_i;
        // Events set flags regardless of the interrupt enable, but only while ce_i is high; a set in the clearing cycle wins.
        flags_nxt = (((flags_r & ~link.flag_clr) | event_i) & LATCHED_MASK) | (level_now & LEVEL_MASK);
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_r <= FLAGS_RESET;
        end else if (ce_i) begin
            flags_r <= flags_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== verif/pirq_assertions.sv ====
// Checker of bus timing, gating and flag behaviour of the interrupt enable block.
`timescale 1ns/1ps
`default_nettype none
module pirq_checker (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [7:0] event_i,
    input wire logic serial_rx_full_i,
    input wire logic serial_tx_empty_i,
    input wire logic [7:0] peripheral_irq_enable_o,
    input wire logic [7:0] peripheral_irq_flags_o,
    input wire logic irq_o
);
    wire logic [7:0] en = peripheral_irq_enable_o;
    wire logic [7:0] fl = peripheral_irq_flags_o;
    wire logic wc = avs_write_i && !avs_waitrequest_o && ce_i;
    wire logic wc8 = wc && avs_address_i == 8'h8C;
    wire logic wc0 = wc && avs_address_i == 8'h0C;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    sequence s_take;
        (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i;
    endsequence
    sequence s_clr;
        wc0 && event_i == 8'h00 ##1 event_i == 8'h00 && ce_i;
    endsequence
    sequence s_event;
        (event_i & 8'hC7) != 8'h00 && ce_i ##1 ce_i;
    endsequence
    a_wait_one: assert property (s_take |=> !avs_waitrequest_o)
        else $error("no answer after one wait cycle");
    a_wait_pulse: assert property (!avs_waitrequest_o && ce_i |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_en_write: assert property (wc8 |=> {24'h0, en} == ($past(avs_writedata_i) & 32'hF7))
        else $error("enable write wrong");
    a_en_hold: assert property ($changed(en) |-> $past(wc8))
        else $error("enable changed without write");
    a_bit_three: assert property (!en[3] && !fl[3] && avs_readdata_o[31:8] == 24'h0)
        else $error("unimplemented bits not zero");
    a_irq_gate: assert property ($past(ce_i) |-> irq_o == |(fl & $past(en)))
        else $error("interrupt output not gated");
    a_flag_set: assert property (s_event |=> (fl & $past(event_i, 2) & 8'hC7) == ($past(event_i, 2) & 8'hC7))
        else $error("event flag not set");
    a_level_copy: assert property ($past(nrst_i, 2) && $past(ce_i) && $past(ce_i, 2)
        |-> fl[5:4] == {$past(serial_rx_full_i, 2), $past(serial_tx_empty_i, 2)})
        else $error("level flag not copied");
    a_w1c_clear: assert property (s_clr |=> ({24'h0, fl} & $past(avs_writedata_i, 2) & 32'hC7) == 32'h0)
        else $error("flag not cleared");
    a_flag_sticky: assert property ($past(ce_i) && $past(ce_i, 2) && ($past(fl) & ~fl & 8'hC7) != 8'h00
        |-> $past(wc0, 2))
        else $error("flag fell on its own");
endmodule
bind peripheral_irq_enable_gating pirq_checker chk_u (.*);
`default_nettype wire

// ==== verif/test_peripheral_irq_enable_gating.sv ====
// Self-checking bench of the peripheral interrupt enable block.
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_irq_enable_gating;
    import pirq_pkg::*;
    localparam logic [7:0] EN_A = PERIPHERAL_IRQ_ENABLE_OFFSET;
    localparam logic [7:0] FL_A = PERIPHERAL_IRQ_FLAGS_OFFSET;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [7:0] ev = 8'h00;
    logic rx_full = 1'b0;
    logic tx_empty = 1'b0;
    logic [31:0] rdata;
    logic wait_r;
    logic [7:0] en_o;
    logic [7:0] fl_o;
    logic irq_o;
    int n_errors = 0;
    int checks_done = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    peripheral_irq_enable_gating dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r), .event_i(ev), .serial_rx_full_i(rx_full),
        .serial_tx_empty_i(tx_empty), .peripheral_irq_enable_o(en_o), .peripheral_irq_flags_o(fl_o),
        .irq_o(irq_o));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        addr <= a;
        wdata <= {24'h0, d};
        wr <= w;
        rd <= !w;
        @(posedge clk_sys_i);
        while (wait_r !== 1'b0) begin
            @(posedge clk_sys_i);
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic get(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h0, e});
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk({31'h0, irq_o}, {31'h0, e});
        @(posedge clk_sys_i);
    endtask
    task automatic t_reset();
        get(EN_A, ENABLE_RESET);
        get(FL_A, FLAGS_RESET);
        irq_is(1'b0);
    endtask
    task automatic t_enable();
        put(EN_A, 8'hFF);
        get(EN_A, IMPL_MASK);
        chk({24'h0, en_o}, {24'h0, IMPL_MASK});
        put(8'h44, 8'hFF);
        get(8'h44, 8'h00);
        put(EN_A, 8'h00);
        get(EN_A, 8'h00);
    endtask
    task automatic t_flags();
        ev <= 8'hFF;
        rx_full <= 1'b1;
        tx_empty <= 1'b1;
        @(posedge clk_sys_i);
        ev <= 8'h00;
        irq_is(1'b0);
        get(FL_A, IMPL_MASK);
        chk({24'h0, fl_o}, {24'h0, IMPL_MASK});
        get(EN_A, 8'h00);
        get(FL_A, IMPL_MASK);
        put(FL_A, 8'hFF);
        get(FL_A, LEVEL_MASK);
        rx_full <= 1'b0;
        tx_empty <= 1'b0;
        @(posedge clk_sys_i);
        get(FL_A, 8'h00);
    endtask
    task automatic t_freeze();
        put(FL_A, 8'hFF);
        put(EN_A, 8'h01);
        ce <= 1'b0;
        ev <= 8'h01;
        repeat (3) @(posedge clk_sys_i);
        ev <= 8'h00;
        @(posedge clk_sys_i);
        ce <= 1'b1;
        irq_is(1'b0);
        get(FL_A, 8'h00);
        put(EN_A, 8'h00);
    endtask
    task automatic t_gating();
        for (int i = 0; i < 8; i++) begin
            put(FL_A, 8'hFF);
            put(EN_A, 8'h01 << i);
            ev <= 8'h01 << i;
            rx_full <= (i == 5);
            tx_empty <= (i == 4);
            @(posedge clk_sys_i);
            ev <= 8'h00;
            irq_is(i != 3);
            rx_full <= 1'b0;
            tx_empty <= 1'b0;
            put(FL_A, 8'h01 << i);
            irq_is(1'b0);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        t_reset();
        t_enable();
        t_flags();
        t_gating();
        t_freeze();
        report_and_stop();
    end
    initial begin
        #100us;
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
